// File: rcft_pkg.sv
// package for the reference clock fraction trim stage
// assumes a 200 MHz peripheral clock and an avalon-mm register bus
//
// Behaviour
// - nine-bit trim in bits 31..23; value n adds n/512 to divisor.
// - while enabled, a written trim waits for a divisor-switch request.
// - trim is ignored whenever the integer divisor is zero.
// - trim resets to zero; bits 22..0 read as zero.
package rcft_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0]  RCFT_CTRL_ADDR   = 4'h0; // reference_clock_control
    localparam logic [3:0]  RCFT_TRIM_ADDR   = 4'h4; // reference_clock_fraction_trim
    localparam int          RCFT_TRIM_LSB    = 23;
    localparam int          RCFT_TRIM_W      = 9;
    localparam int          RCFT_DIV_W       = 15;
    localparam int          RCFT_CTRL_ON     = 15;
    localparam int          RCFT_CTRL_SWREQ  = 9;
    localparam int          RCFT_CTRL_ACTIVE = 8;
    localparam int          RCFT_CTRL_DIVLSB = 16;
    localparam logic [8:0]  RCFT_TRIM_RST    = 9'h000;
    localparam logic [14:0] RCFT_DIV_RST     = 15'h0000;
    localparam logic [31:0] RCFT_ZERO32      = 32'h0000_0000;

    // divider settings that travel together
    typedef struct packed {
        logic [14:0] div;
        logic [8:0]  trim;
    } rcft_setting_s;
endpackage

// File: rcft_top.sv
// reference clock fraction trim stage with its control register
// holds the control and trim registers, the trim hold-off and the
// fractional divider that makes the reference clock output
// assumes an avalon-mm master that holds a request until waitrequest is
// low; src_tick_i is a one-cycle enable, one per source clock cycle
// all inputs are synchronous to ref_clk_i; rst_i is synchronous
`timescale 1ns/100ps
module rcft_top
    import rcft_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        src_tick_i,
    output logic             ref_clk_out_o,
    output logic             active_o
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic          on_bit, next_on_bit;        // generator enable
    logic          active, next_active;        // generator running status
    logic          sw_req, next_sw_req;        // divisor switch request, one cycle
    logic [8:0]    trim_pend, next_trim_pend;  // trim as last written
    rcft_setting_s live, next_live;            // settings the divider runs on
    logic [31:0]   rdata, next_rdata;
    logic          rvalid, next_rvalid;
    logic          wr_ctrl, wr_trim, rd_start;
    logic          req_bit;                    // switch request seen in write data
    logic [31:0]   ctrl_rd, trim_rd, ctrl_m, trim_m;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // byte-lane merge used by both registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // register address compare; one place for the read and the write decode
    function automatic logic addr_is(input logic [3:0] adr, input logic [3:0] reg_adr);
        return adr == reg_adr;
    endfunction

    // control word as software sees it; unlisted bits read as zero
    function automatic logic [31:0] pack_ctrl(input logic [14:0] div, input logic enable,
                                              input logic req, input logic act);
        logic [31:0] w;
        w = RCFT_ZERO32;
        w[RCFT_CTRL_DIVLSB +: RCFT_DIV_W] = div;
        w[RCFT_CTRL_ON]                    = enable;
        w[RCFT_CTRL_SWREQ]                 = req;
        w[RCFT_CTRL_ACTIVE]                = act;
        return w;
    endfunction

    // trim word: only the nine trim bits are implemented
    function automatic logic [31:0] pack_trim(input logic [8:0] trim);
        logic [31:0] w;
        w = RCFT_ZERO32;
        w[RCFT_TRIM_LSB +: RCFT_TRIM_W] = trim;
        return w;
    endfunction

    // last tick of a half period; a carry stretches it by one tick
    function automatic logic half_done(input logic [15:0] count, input logic [14:0] div,
                                       input logic stretch);
        return (count + 16'h0001) >= ({1'b0, div} + {15'h0000, stretch});
    endfunction

    // ------------------------------------------------------------
    // bus decode and answer
    // ------------------------------------------------------------
    // read-back words and their lane-merged write images
    assign ctrl_rd  = pack_ctrl(live.div, on_bit, sw_req, active);
    assign trim_rd  = pack_trim(trim_pend);
    assign ctrl_m   = merge(ctrl_rd, avs_writedata_i, avs_byteenable_i);
    assign trim_m   = merge(trim_rd, avs_writedata_i, avs_byteenable_i);
    // write strobes; unmapped addresses are simply dropped
    assign wr_ctrl  = avs_write_i && addr_is(avs_address_i, RCFT_CTRL_ADDR);
    assign wr_trim  = avs_write_i && addr_is(avs_address_i, RCFT_TRIM_ADDR);
    // the switch request is a strobe, so it comes from the written lane
    // itself and never from the merged read-back, which would re-arm it
    assign req_bit  = wr_ctrl && avs_byteenable_i[RCFT_CTRL_SWREQ / 8]
                      && avs_writedata_i[RCFT_CTRL_SWREQ];
    // writes finish at once; reads wait one cycle for registered data
    assign rd_start          = avs_read_i && !rvalid;
    assign avs_waitrequest_o = rd_start;
    assign avs_readdata_o    = rdata;
    assign active_o          = active;

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------
    // data is captured in the waiting cycle and shown in the next one;
    // it drops back to zero after, so stale words never linger
    always_comb
    begin
        next_rvalid = rd_start;
        next_rdata  = RCFT_ZERO32; // unmapped reads give zero
        if (rd_start)
        begin
            if (addr_is(avs_address_i, RCFT_CTRL_ADDR))
            begin
                next_rdata = ctrl_rd;
            end
            else if (addr_is(avs_address_i, RCFT_TRIM_ADDR))
            begin
                next_rdata = trim_rd;
            end
        end
    end

    // read registers
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            rdata  <= RCFT_ZERO32;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // ------------------------------------------------------------
    // control and trim registers
    // ------------------------------------------------------------
    // while off, a written trim goes straight to the divider; while on, it
    // waits in trim_pend until software raises the switch request
    always_comb
    begin
        next_on_bit    = on_bit;
        next_sw_req    = sw_req;
        next_trim_pend = trim_pend;
        next_live      = live;
        if (wr_trim)
        begin
            next_trim_pend = trim_m[RCFT_TRIM_LSB +: RCFT_TRIM_W];
        end
        if (wr_ctrl)
        begin
            next_on_bit   = ctrl_m[RCFT_CTRL_ON];
            next_live.div = ctrl_m[RCFT_CTRL_DIVLSB +: RCFT_DIV_W];
        end
        if (!on_bit)
        begin
            // nothing is held back while the generator is off
            next_live.trim = next_trim_pend;
            next_sw_req    = 1'b0;
        end
        else if (sw_req)
        begin
            next_live.trim = trim_pend;
            // a request written in the same cycle still stands: set wins
            next_sw_req    = req_bit;
        end
        else if (req_bit)
        begin
            next_sw_req = 1'b1;
        end
    end

    // settings registers; the trim reset value makes the divider run
    // untrimmed until software writes
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            on_bit    <= 1'b0;
            sw_req    <= 1'b0;
            trim_pend <= RCFT_TRIM_RST;
            live      <= '{div: RCFT_DIV_RST, trim: RCFT_TRIM_RST};
        end
        else
        begin
            on_bit    <= next_on_bit;
            sw_req    <= next_sw_req;
            trim_pend <= next_trim_pend;
            live      <= next_live;
        end
    end

    // ------------------------------------------------------------
    // generator status
    // ------------------------------------------------------------
    // active follows the enable one cycle late; software must see the two
    // agree before it writes the trim register
    always_comb
    begin
        next_active = on_bit;
    end

    // status register
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            active <= 1'b0;
        end
        else
        begin
            active <= next_active;
        end
    end

    // ------------------------------------------------------------
    // fractional divider
    // ------------------------------------------------------------
    // each output half period lasts div source ticks; the fraction is
    // added once per half period, so each half carries div + trim/512
    // on average and a full period is twice the combined divisor
    logic [15:0] cnt, next_cnt;     // ticks spent in this half period
    logic [8:0]  acc, next_acc;     // fraction accumulator, 1/512 units
    logic        extra, next_extra; // carry: stretch this half by a tick
    logic        clk_q, next_clk_q; // output phase
    logic [9:0]  acc_sum;
    logic        bypass;            // zero divisor: trim has no effect
    logic        at_end;            // last tick of the current half

    assign acc_sum = {1'b0, acc} + {1'b0, live.trim};
    assign bypass  = live.div == RCFT_DIV_RST;
    assign at_end  = half_done(cnt, live.div, extra);

    // half-period counter and output phase
    always_comb
    begin
        next_cnt   = cnt;
        next_clk_q = clk_q;
        if (!active)
        begin
            next_cnt   = 16'h0000;
            next_clk_q = 1'b0;
        end
        else if (bypass)
        begin
            next_cnt   = 16'h0000;
            next_clk_q = src_tick_i; // undivided; trim ignored
        end
        else if (src_tick_i)
        begin
            if (at_end)
            begin
                next_cnt   = 16'h0000;
                next_clk_q = !clk_q;
            end
            else
            begin
                next_cnt = cnt + 16'h0001;
            end
        end
    end

    // fraction accumulator: steps at every output edge; its carry
    // lengthens the half period that starts there, which spreads the
    // extra source ticks evenly instead of bunching them
    always_comb
    begin
        next_acc   = acc;
        next_extra = extra;
        if (!active || bypass)
        begin
            next_acc   = 9'h000;
            next_extra = 1'b0;
        end
        else if (src_tick_i && at_end)
        begin
            next_acc   = acc_sum[8:0];
            next_extra = acc_sum[9];
        end
    end

    // divider registers
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cnt   <= 16'h0000;
            clk_q <= 1'b0;
        end
        else
        begin
            cnt   <= next_cnt;
            clk_q <= next_clk_q;
        end
    end

    // accumulator registers
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            acc   <= 9'h000;
            extra <= 1'b0;
        end
        else
        begin
            acc   <= next_acc;
            extra <= next_extra;
        end
    end

    // output straight from the phase flip-flop, so it carries no glitches
    assign ref_clk_out_o = clk_q;
endmodule // rcft_top

// File: rcft_top_chk.sv
// checker: bus timing, trim read-back, enable echo, divider bypass
// assumes it is bound onto rcft_top
`timescale 1ns/100ps
module rcft_chk
    import rcft_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        src_tick_i,
    input wire logic        ref_clk_out_o,
    input wire logic        active_o
);
    logic dz; // divisor last written as zero
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    // shadow of the divisor; bench always writes whole words
    always_ff @(posedge ref_clk_i)
        if (rst_i)
            dz <= 1'b1;
        else if (avs_write_i && avs_address_i == RCFT_CTRL_ADDR)
            dz <= avs_writedata_i[30:16] == 15'h0000;
    property p_wr; avs_write_i |-> !avs_waitrequest_o; endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_rd; $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
    a_rd: assert property (p_rd) else $error("read wait wrong");
    property p_trim; avs_read_i && !avs_waitrequest_o && avs_address_i == RCFT_TRIM_ADDR
        |-> avs_readdata_o[22:0] == 23'h000000; endproperty
    a_trim: assert property (p_trim) else $error("trim low bits set");
    property p_act; avs_write_i && avs_address_i == RCFT_CTRL_ADDR
        |-> ##2 active_o == $past(avs_writedata_i[15], 2); endproperty
    a_act: assert property (p_act) else $error("active not echoed");
    property p_byp; dz && $past(dz) && active_o |-> ref_clk_out_o == $past(src_tick_i);
    endproperty
    a_byp: assert property (p_byp) else $error("trim used at zero divisor");
    c_trim: cover property (avs_read_i && avs_address_i == RCFT_TRIM_ADDR);
    c_sw: cover property (avs_write_i && avs_writedata_i[9]);
    c_byp: cover property (dz && active_o);
endmodule // rcft_chk

// File: rcft_top_tb.sv
// self-checking bench for the fraction trim stage
// assumes rcft_pkg and rcft_chk compiled first
`timescale 1ns/100ps
module rcft_top_tb
    import rcft_pkg::*;
;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic        tick = 1'b0;
    logic [31:0] rdat;
    logic        wait_o;
    logic        clk_o;
    logic        act;
    logic [31:0] q;
    int          fails = 0;
    int          comparisons = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    // tick every other clock, so one tick spans two clocks
    always @(posedge ref_clk_i) tick <= ~tick;
    rcft_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
        .src_tick_i(tick), .ref_clk_out_o(clk_o), .active_o(act));
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk_i);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge ref_clk_i); while (wait_o !== 1'b0);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // clocks across two output periods, after settling
    task automatic per(output logic [31:0] c);
        time t0;
        repeat (3) @(posedge clk_o);
        t0 = $time;
        repeat (2) @(posedge clk_o);
        c = 32'(($time - t0) / 5);
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        bus(1'b0, RCFT_TRIM_ADDR, RCFT_ZERO32, q);
        chk(q, RCFT_ZERO32);
        bus(1'b1, RCFT_TRIM_ADDR, 32'hFFFF_FFFF, q);
        bus(1'b0, RCFT_TRIM_ADDR, RCFT_ZERO32, q);
        chk(q, 32'hFF80_0000);
        bus(1'b1, 4'h8, 32'hFFFF_FFFF, q);
        bus(1'b0, 4'h8, RCFT_ZERO32, q);
        chk(q, RCFT_ZERO32);
        bus(1'b1, RCFT_TRIM_ADDR, RCFT_ZERO32, q);
        bus(1'b1, RCFT_CTRL_ADDR, 32'h0002_8000, q);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, act}, 32'h0000_0001);
        bus(1'b1, RCFT_TRIM_ADDR, 32'h8000_0000, q);
        per(q);
        chk(q, 32'h0000_0010);
        bus(1'b1, RCFT_CTRL_ADDR, 32'h0002_8200, q);
        per(q);
        chk(q, 32'h0000_0014);
        bus(1'b0, RCFT_CTRL_ADDR, RCFT_ZERO32, q);
        chk(q, 32'h0002_8100);
        bus(1'b1, RCFT_CTRL_ADDR, 32'h0000_8000, q);
        repeat (40) @(posedge ref_clk_i);
        per(q);
        chk(q, 32'h0000_0004);
        report_and_stop();
    end
    // hang guard, far beyond the few hundred clocks the tests need
    initial
    begin
        #100000;
        fails++;
        report_and_stop();
    end
endmodule // rcft_top_tb
bind rcft_top rcft_chk chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .src_tick_i(src_tick_i),
    .ref_clk_out_o(ref_clk_out_o), .active_o(active_o));
